// ### rtl/sstp_top.sv
`default_nettype none

module sstp_top (
   // clock and reset
   input  wire logic                            I_SYS_CLK,
   input  wire logic                            I_RST_N,
   // apb slave
   input  wire logic                            I_PSEL,
   input  wire logic                            I_PENABLE,
   input  wire logic                            I_PWRITE,
   input  wire logic [sstp_pkg::ADDR_W-1:0]     I_PADDR,
   input  wire logic [sstp_pkg::DATA_W-1:0]     I_PWDATA,
   output logic                                 O_PREADY,
   output logic      [sstp_pkg::DATA_W-1:0]     O_PRDATA,
   output logic                                 O_PSLVERR,
   // port pins
   input  wire logic [sstp_pkg::PORT_W-1:0]     I_PORT_PIN,
   output logic      [sstp_pkg::PORT_W-1:0]     O_PORT_PIN,
   output logic      [sstp_pkg::PORT_W-1:0]     O_PORT_OE
);

   import sstp_pkg::*;

   logic [PORT_W-1:0]  pin_q;
   logic [PORT_W-1:0]  pin_inv;

   logic [PRE_W-1:0]   pre_q;
   logic [PRE_W-1:0]   pre_d;
   logic               mtick;

   logic               acc;
   logic               wr_fire;
   logic               sel_data;
   logic               sel_dir;
   logic               sel_ctrl;
   logic               sel_stat;
   logic               sel_any;
   logic               pready_q;
   logic               pready_d;
   logic               pslverr_q;
   logic               pslverr_d;
   logic [DATA_W-1:0]  prdata_q;
   logic [DATA_W-1:0]  prdata_d;
   logic               run_q;
   logic               run_d;

   sstp_state_t        st_q;
   sstp_state_t        st_d;
   logic [PORT_W-1:0]  data_q;
   logic [PORT_W-1:0]  data_d;
   logic [PORT_W-1:0]  dir_q;
   logic [PORT_W-1:0]  dir_d;
   logic [CNT_W-1:0]   cnt_q;
   logic [CNT_W-1:0]   cnt_d;
   logic               dirw_q;
   logic               dirw_d;
   logic               toggle;
   logic               sample;
   logic               t_load;
   logic [TIMER_W-1:0] t_len;
   logic               t_done;
   logic [TIMER_W-1:0] dly_len;

   logic [TIMER_W-1:0] mc_since_q;
   logic [TIMER_W-1:0] st_ticks_q;
   logic               have_prev_q;

   // pin levels cross into the clock domain
   sstp_sync #(
      .W (PORT_W)
   ) u_sync (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (I_RST_N),
      .i_d     (I_PORT_PIN),
      .o_q     (pin_q)
   );

   sstp_mc_timer #(
      .W (TIMER_W)
   ) u_timer (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (I_RST_N),
      .i_load  (t_load),
      .i_len   (t_len),
      .i_tick  (mtick),
      .o_done  (t_done)
   );

   // machine cycle tick from the system clock
   always_comb begin
      mtick = (pre_q == PRE_LAST);
      pre_d = mtick ? '0 : pre_q + 1'b1;
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_d;
      end
   end

   // apb decode and answer
   always_comb begin
      acc      = I_PSEL && I_PENABLE;
      wr_fire  = acc && pready_q && I_PWRITE;
      sel_data = (I_PADDR == ADDR_DATA);
      sel_dir  = (I_PADDR == ADDR_DIR);
      sel_ctrl = (I_PADDR == ADDR_CTRL);
      sel_stat = (I_PADDR == ADDR_STAT);
      sel_any  = sel_data || sel_dir || sel_ctrl || sel_stat;
      pready_d  = acc && !pready_q;
      pslverr_d = acc && !pready_q && !sel_any;
      prdata_d  = RD_ZERO;
      run_d     = run_q;
      if (acc && !pready_q && !I_PWRITE) begin
         if (sel_data) begin
            prdata_d[PORT_W-1:0] = pin_q;
         end else if (sel_dir) begin
            prdata_d[PORT_W-1:0] = dir_q;
         end else if (sel_ctrl) begin
            prdata_d[CTRL_RUN_BIT] = run_q;
         end else if (sel_stat) begin
            prdata_d[CNT_W-1:0]     = cnt_q;
            prdata_d[STAT_BUSY_BIT] = (st_q != S_IDLE);
            prdata_d[STAT_DIRW_BIT] = dirw_q;
         end
      end
      if (wr_fire && sel_ctrl) begin
         run_d = I_PWDATA[CTRL_RUN_BIT];
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= RD_ZERO;
         run_q     <= 1'b0;
      end else begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
         run_q     <= run_d;
      end
   end

   // tone sequencer: set direction, then toggle, read, delay, branch
   always_comb begin
      pin_inv = ~pin_q;
      dly_len = MC_PASS * TIMER_W'(cnt_q) + MC_EXIT;
      st_d    = st_q;
      data_d  = data_q;
      dir_d   = dir_q;
      cnt_d   = cnt_q;
      dirw_d  = dirw_q;
      toggle  = 1'b0;
      sample  = 1'b0;
      t_load  = 1'b0;
      t_len   = MC_TOGGLE;
      if (!run_q) begin
         st_d   = S_IDLE;
         dirw_d = 1'b0;
      end else begin
         case (st_q)
            S_IDLE: begin
               st_d   = S_INIT;
               t_load = 1'b1;
               t_len  = MC_INIT;
            end
            S_INIT: begin
               if (t_done) begin
                  dir_d  = DIR_TONE;
                  dirw_d = 1'b1;
                  st_d   = S_TOGGLE;
                  t_load = 1'b1;
                  t_len  = MC_TOGGLE;
               end
            end
            S_TOGGLE: begin
               if (t_done) begin
                  toggle = 1'b1;
                  data_d = pin_q + 1'b1;
                  st_d   = S_READ;
                  t_load = 1'b1;
                  t_len  = MC_READ;
               end
            end
            S_READ: begin
               if (t_done) begin
                  sample = 1'b1;
                  cnt_d  = CNT_W'(pin_inv >> 1);
                  st_d   = S_PREP;
                  t_load = 1'b1;
                  t_len  = MC_PREP;
               end
            end
            S_PREP: begin
               if (t_done) begin
                  st_d   = S_DELAY;
                  t_load = 1'b1;
                  t_len  = dly_len;
               end
            end
            S_DELAY: begin
               if (t_done) begin
                  st_d   = S_BRANCH;
                  t_load = 1'b1;
                  t_len  = MC_BRANCH;
               end
            end
            S_BRANCH: begin
               if (t_done) begin
                  st_d   = S_TOGGLE;
                  t_load = 1'b1;
                  t_len  = MC_TOGGLE;
               end
            end
            default: begin
               st_d = S_IDLE;
            end
         endcase
      end
      // software writes win over the sequencer in the same cycle
      if (wr_fire && sel_data) begin
         data_d = I_PWDATA[PORT_W-1:0];
      end
      if (wr_fire && sel_dir) begin
         dir_d = I_PWDATA[PORT_W-1:0];
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         st_q   <= S_IDLE;
         data_q <= DATA_RST;
         dir_q  <= DIR_RST;
         cnt_q  <= '0;
         dirw_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         data_q <= data_d;
         dir_q  <= dir_d;
         cnt_q  <= cnt_d;
         dirw_q <= dirw_d;
      end
   end

   // outputs straight from flops
   always_comb begin
      O_PREADY   = pready_q;
      O_PSLVERR  = pslverr_q;
      O_PRDATA   = prdata_q;
      O_PORT_PIN = data_q;
      O_PORT_OE  = dir_q;
   end

   // cycle counters watched by the checks below
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         mc_since_q  <= '0;
         st_ticks_q  <= '0;
         have_prev_q <= 1'b0;
      end else begin
         if (toggle) begin
            mc_since_q <= '0;
         end else if (mtick) begin
            mc_since_q <= mc_since_q + 1'b1;
         end
         if (t_load) begin
            st_ticks_q <= '0;
         end else if (mtick) begin
            st_ticks_q <= st_ticks_q + 1'b1;
         end
         have_prev_q <= run_q && (have_prev_q || toggle);
      end
   end

   property p_dir_write;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (wr_fire && sel_dir) |=> (O_PORT_OE == $past(I_PWDATA[PORT_W-1:0]));
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("pin enables do not follow direction write");

   property p_dir_init;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (st_q == S_INIT && t_done && !(wr_fire && sel_dir)) |=>
         (O_PORT_OE == DIR_TONE) && (st_q == S_TOGGLE);
   endproperty
   a_dir_init: assert property (p_dir_init)
      else $error("initial direction not set to pin 0 output");

   property p_data_read;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (acc && !I_PWRITE && sel_data && !pready_q) |=>
         (O_PREADY && O_PRDATA == DATA_W'($past(pin_q)));
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("data read does not return pin levels");

   property p_toggle;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (toggle && !(wr_fire && sel_data)) |=> (O_PORT_PIN[0] == !$past(pin_q[0]));
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("tone pin not inverted on toggle");

   property p_msb;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      sample |=> (cnt_q[CNT_W-1] == !$past(pin_q[PORT_W-1])) &&
                 (cnt_q[0] == !$past(pin_q[1]));
   endproperty
   a_msb: assert property (p_msb)
      else $error("switch bit order wrong");

   property p_closed;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (sample && pin_q[PORT_W-1:1] == '0) |=> (cnt_q == '1);
   endproperty
   a_closed: assert property (p_closed)
      else $error("closed switches do not read as one");

   property p_count;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      sample |=> (cnt_q == ~$past(pin_q[PORT_W-1:1]));
   endproperty
   a_count: assert property (p_count)
      else $error("switch count is not shifted complement");

   property p_tick;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      mtick |=> !mtick [*8];
   endproperty
   a_tick: assert property (p_tick)
      else $error("machine cycle tick too frequent");

   property p_half;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (toggle && have_prev_q) |->
         (2 * (int'(mc_since_q) + 1) == TONE_BASE_MC + TONE_STEP_MC * int'(cnt_q));
   endproperty
   a_half: assert property (p_half)
      else $error("half period does not match switch count");

   property p_delay;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (st_q == S_DELAY && t_done && run_q) |->
         (int'(st_ticks_q) + 1 == int'(MC_PASS) * int'(cnt_q) + int'(MC_EXIT));
   endproperty
   a_delay: assert property (p_delay)
      else $error("delay loop length wrong");

   property p_order;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      toggle |-> dirw_q ##1 (st_q == S_READ);
   endproperty
   a_order: assert property (p_order)
      else $error("toggle before direction set");

endmodule : sstp_top

`default_nettype wire

// ### include/sstp_pkg.sv
`default_nettype none

package sstp_pkg;

   // widths
   localparam int ADDR_W  = 16;
   localparam int DATA_W  = 32;
   localparam int PORT_W  = 8;
   localparam int CNT_W   = PORT_W - 1;
   localparam int TIMER_W = 10;
   localparam int PRE_W   = 7;

   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_DATA = 16'h1700;
   localparam logic [ADDR_W-1:0] IDX_DIR  = 16'h1701;
   localparam logic [ADDR_W-1:0] IDX_CTRL = 16'h1702;
   localparam logic [ADDR_W-1:0] IDX_STAT = 16'h1703;

   localparam logic [ADDR_W-1:0] ADDR_DATA = {IDX_DATA[ADDR_W-3:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_DIR  = {IDX_DIR[ADDR_W-3:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL[ADDR_W-3:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STAT = {IDX_STAT[ADDR_W-3:0], 2'b00};

   // reset and fixed values
   localparam logic [PORT_W-1:0] DATA_RST = 8'h00;
   localparam logic [PORT_W-1:0] DIR_RST  = 8'h00;
   localparam logic [PORT_W-1:0] DIR_TONE = 8'h01;
   localparam logic [DATA_W-1:0] RD_ZERO  = 32'h0000_0000;

   // field positions
   localparam int CTRL_RUN_BIT  = 0;
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_DIRW_BIT = 9;

   // machine cycle derived from the system clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int MCYCLE_NS     = 1000;
   localparam int CLKS_PER_MC   = (MCYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CLKS_PER_MC - 1);

   // machine cycles per step of the tone loop
   localparam logic [TIMER_W-1:0] MC_INIT   = 10'h006;
   localparam logic [TIMER_W-1:0] MC_TOGGLE = 10'h006;
   localparam logic [TIMER_W-1:0] MC_READ   = 10'h004;
   localparam logic [TIMER_W-1:0] MC_PREP   = 10'h006;
   localparam logic [TIMER_W-1:0] MC_PASS   = 10'h005;
   localparam logic [TIMER_W-1:0] MC_EXIT   = 10'h004;
   localparam logic [TIMER_W-1:0] MC_BRANCH = 10'h003;

   // full period in machine cycles: base plus step per count
   localparam int TONE_BASE_MC = 46;
   localparam int TONE_STEP_MC = 10;

   typedef enum logic [2:0] {
      S_IDLE,
      S_INIT,
      S_TOGGLE,
      S_READ,
      S_PREP,
      S_DELAY,
      S_BRANCH
   } sstp_state_t;

endpackage : sstp_pkg

`default_nettype wire

// ### rtl/sstp_sync.sv
`default_nettype none

module sstp_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   // levels
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   logic [W-1:0] meta_q;

   // two flops per pin; first stage feeds only the second
   for (genvar b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge i_clk) begin
         if (!i_rst_n) begin
            meta_q[b] <= 1'b0;
            o_q[b]    <= 1'b0;
         end else begin
            meta_q[b] <= i_d[b];
            o_q[b]    <= meta_q[b];
         end
      end
   end

endmodule : sstp_sync

`default_nettype wire

// ### rtl/sstp_mc_timer.sv
`default_nettype none

module sstp_mc_timer #(
   parameter int W = 10
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   // control
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_len,
   input  wire logic         i_tick,
   // status
   output logic              o_done
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   // done on the tick that ends the loaded number of machine cycles
   always_comb begin
      o_done = i_tick && (cnt_q == W'(1));
      cnt_d  = cnt_q;
      if (i_load) begin
         cnt_d = i_len;
      end else if (i_tick && (cnt_q != '0)) begin
         cnt_d = cnt_q - W'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule : sstp_mc_timer

`default_nettype wire

// ### verification/sstp_pad_model.sv
`default_nettype none

module sstp_pad_model (
   // pins from the block
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_oe,
   // switch settings, 1 = closed
   input  wire logic [6:0] i_closed,
   // resolved pad levels
   output logic      [7:0] o_pad
);
   timeunit 1ns;
   timeprecision 1ps;

   // released pads float high on pull-ups; a closed switch grounds its pin
   always_comb begin
      o_pad[0] = i_oe[0] ? i_out[0] : 1'b1;
      for (int i = 1; i < 8; i++) begin
         o_pad[i] = i_oe[i] ? i_out[i] : ~i_closed[i-1];
      end
   end
endmodule : sstp_pad_model

`default_nettype wire

// ### verification/sstp_top_tb.sv
`default_nettype none

module sstp_top_tb;
   import sstp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic                clk;
   logic                rst_n;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [ADDR_W-1:0]   paddr;
   logic [DATA_W-1:0]   pwdata;
   logic                pready;
   logic [DATA_W-1:0]   prdata;
   logic                pslverr;
   logic [PORT_W-1:0]   pad;
   logic [PORT_W-1:0]   pin_out;
   logic [PORT_W-1:0]   pin_oe;
   logic [6:0]          closed;
   int                  error_cnt;
   int                  compares;
   logic [DATA_W-1:0]   rd;
   logic                err;
   int                  n;

   sstp_top i_dut (
      .I_SYS_CLK  (clk),
      .I_RST_N    (rst_n),
      .I_PSEL     (psel),
      .I_PENABLE  (penable),
      .I_PWRITE   (pwrite),
      .I_PADDR    (paddr),
      .I_PWDATA   (pwdata),
      .O_PREADY   (pready),
      .O_PRDATA   (prdata),
      .O_PSLVERR  (pslverr),
      .I_PORT_PIN (pad),
      .O_PORT_PIN (pin_out),
      .O_PORT_OE  (pin_oe)
   );

   sstp_pad_model i_pads (
      .i_out    (pin_out),
      .i_oe     (pin_oe),
      .i_closed (closed),
      .o_pad    (pad)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   task automatic idle(input int c);
      repeat (c) @(posedge clk);
   endtask : idle

   // one apb transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic serr);
      int w;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      w = 0;
      @(posedge clk);
      while (pready !== 1'b1 && w < 50) begin
         w++;
         @(posedge clk);
      end
      if (w >= 50) check(32'h0000_0001, 32'h0000_0000);
      rdat = prdata;
      serr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // clocks until the tone pin next changes
   task automatic wait_tog(output int c);
      logic last;
      last = pin_out[0];
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (pin_out[0] === last && c < 80000);
   endtask : wait_tog

   function automatic logic [31:0] pads(input logic [6:0] sw, input logic p0);
      return {24'h0000_00, ~sw, p0};
   endfunction : pads

   initial begin
      error_cnt = 0;
      compares  = 0;
      rst_n   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 16'h0000;
      pwdata  = 32'h0000_0000;
      closed  = 7'h00;
      idle(20);
      rst_n <= 1'b1;
      idle(2);
      check({pin_oe, pin_out}, {DIR_RST, DATA_RST});
      apb(1'b0, ADDR_DATA, 32'h0, rd, err);
      check(rd, pads(7'h00, 1'b1));
      closed <= 7'h05;
      apb(1'b1, ADDR_DIR, {24'h0, DIR_TONE}, rd, err);
      idle(4);
      check({24'h0, pin_oe}, 32'h0000_0001);
      apb(1'b0, ADDR_DIR, 32'h0, rd, err);
      check(rd, 32'h0000_0001);
      for (int v = 0; v < 2; v++) begin
         apb(1'b1, ADDR_DATA, 32'h0000_00FE | v, rd, err);
         idle(4);
         apb(1'b0, ADDR_DATA, 32'h0, rd, err);
         check(rd, pads(7'h05, v[0]));
      end
      apb(1'b0, 16'h0000, 32'h0, rd, err);
      check({rd[30:0], err}, 32'h0000_0001);
      apb(1'b1, 16'h0010, 32'h0000_00FF, rd, err);
      check({31'h0, err}, 32'h0000_0001);
      // engine sets direction itself before the first toggle
      apb(1'b1, ADDR_DIR, 32'h0, rd, err);
      closed <= 7'h00;
      apb(1'b1, ADDR_CTRL, 32'h0000_0001, rd, err);
      wait_tog(n);
      check({24'h0, pin_oe}, {24'h0, DIR_TONE});
      wait_tog(n);
      wait_tog(n);
      check(n, 100 * (TONE_BASE_MC / 2));
      apb(1'b0, ADDR_STAT, 32'h0, rd, err);
      check({rd[9:8], 1'b0, rd[6:0]}, {2'b11, 8'h00});
      closed <= 7'h05;
      wait_tog(n);
      wait_tog(n);
      wait_tog(n);
      check(n, 100 * (TONE_BASE_MC + TONE_STEP_MC * 5) / 2);
      check({24'h0, pin_oe}, 32'h0000_0001);
      apb(1'b0, ADDR_STAT, 32'h0, rd, err);
      check({25'h0, rd[6:0]}, 32'h0000_0005);
      apb(1'b0, ADDR_DATA, 32'h0, rd, err);
      check({24'h0, rd[7:1], 1'b0}, {24'h0, ~7'h05, 1'b0});
      closed <= 7'h12;
      wait_tog(n);
      wait_tog(n);
      check(n, CLKS_PER_MC * (TONE_BASE_MC + TONE_STEP_MC * 18) / 2);
      idle(600);
      apb(1'b0, ADDR_STAT, 32'h0, rd, err);
      check({25'h0, rd[6:0]}, 32'h0000_0012);
      apb(1'b1, ADDR_CTRL, 32'h0, rd, err);
      n = int'(pin_out[0]);
      idle(3000);
      check({31'h0, pin_out[0]}, n);
      apb(1'b0, ADDR_STAT, 32'h0, rd, err);
      check({31'h0, rd[STAT_BUSY_BIT]}, 32'h0);
      end_of_test();
   end

   initial begin
      #800_000;
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule : sstp_top_tb

`default_nettype wire
